// *** pkg/asc_pkg.sv ***
// What this block does
// R1 - controller counts converter clock-output pulses
// R2 - reaching stop bit gives active-low stop pulse
// R3 - stop pulse clears latch driving convert
// R4 - status falls on stop; selection reloads
// R5 - seven one-hot inputs: bit 7 down to 1
// R6 - only the wanted selection input high
// R7 - all selection low: full 12 bits
// R8 - second stage allows stops at 8-11
// R9 - offset binary bipolar, complementary unipolar
// R10 - mid-scale step 0111.. to 1000..
// R11 - full conversion 800 to 900 ns
// R12 - rising convert starts; low resets
// R13 - status high while converting
// R14 - first clock cycle resolves MSB
// R15 - convert low at least 50 ns first
// R16 - latch set again on next request
package asc_pkg;
  localparam int RES_BITS = 12;                  // full result width
  localparam int SEL_BITS = 11;                  // stop selections, bits 11..1
  localparam int CLK_PERIOD_NS = 8;              // core_clk period
  localparam int CONV_MIN_NS = 800;              // least full conversion time
  localparam int CONV_MAX_NS = 900;              // longest full conversion time
  localparam int CONV_LOW_NS = 50;               // least convert low time
  // per-bit cycles: full conversion lands within 800..900 ns
  localparam int BIT_CYC = (CONV_MIN_NS + RES_BITS * CLK_PERIOD_NS - 1)
                           / (RES_BITS * CLK_PERIOD_NS);
  localparam int LOW_CYC = (CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] RESULT_RESET = 12'h7ff; // sar start: msb 0, rest 1
  localparam logic [11:0] MID_CODE = 12'h800;    // bipolar mid-scale code
endpackage

// *** pkg/asc_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// wires between converter and short-cycle controller
interface asc_link_if;
  logic        convertCmd;   // convert command from controller
  logic        clockOut;     // converter bit clock, falling edge = bit valid
  logic        status;       // high while converting
  logic [11:0] resultData;   // parallel result
  logic        serialOut;    // serial result bit
  modport converter (input convertCmd, output clockOut, status, resultData, serialOut);
  modport controller (output convertCmd, input clockOut, status, resultData, serialOut);
endinterface
`default_nettype wire

// *** core/asc_converter.sv ***
`timescale 1ns/100ps
`default_nettype none
// digital model of the converter end: sar sequencing and code formats
module asc_converter
  import asc_pkg::*;
(
  input  wire logic        core_clk,     // system clock
  input  wire logic        sys_rst,      // synchronous reset, active high
  input  wire logic        clkEn,        // clock enable, freezes state when low
  input  wire logic        bipolarMode,  // 1 = bipolar range, 0 = unipolar
  input  wire logic [11:0] sampleCode,   // ideal offset-binary code of the input
  asc_link_if.converter    link          // converter side of the link
);
  typedef enum logic [1:0] {
    AC_IDLE = 2'b00,  // convert low, held in reset
    AC_ARM  = 2'b01,  // convert high, waiting first clock
    AC_CONV = 2'b10,  // resolving bits
    AC_DONE = 2'b11   // result valid
  } asc_conv_state_t;

  asc_conv_state_t stateReg, stateNext;  // sequencer state
  logic [11:0] sarReg, sarNext;          // approximation register
  logic [3:0]  bitReg, bitNext;          // bit being resolved, 11..0
  logic [7:0]  cycReg, cycNext;          // cycles within a bit
  logic        clkReg, clkNext;          // clock output level
  logic        serReg, serNext;          // serial data
  logic [11:0] target;                   // code after format

  //////////////////////////////////////////////////////////////////////////
  // output format: offset binary bipolar, complement for unipolar
  always_comb begin
    target = bipolarMode ? sampleCode : ~sampleCode;  // R9 R10
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    stateNext = stateReg;
    sarNext   = sarReg;
    bitNext   = bitReg;
    cycNext   = cycReg;
    clkNext   = clkReg;
    serNext   = serReg;
    if (!link.convertCmd) begin
      // low convert resets the clock and the sequencer
      // the sar keeps its bits, so a short-cycled result can still be latched
      stateNext = AC_IDLE;  // R12
      clkNext   = 1'b0;
      cycNext   = '0;
    end else begin
      case (stateReg)
        AC_IDLE: begin
          stateNext = AC_ARM;  // R12
        end
        AC_ARM: begin
          // sar preset at the first clock: msb 0, rest 1
          stateNext = AC_CONV;  // R14
          sarNext   = RESULT_RESET;  // R12 R14
          bitNext   = 4'hb;
          cycNext   = '0;
          clkNext   = 1'b1;
        end
        AC_CONV: begin
          cycNext = cycReg + 8'h01;
          if (cycReg == 8'((BIT_CYC / 2) - 1)) begin
            // falling clock: current bit valid
            clkNext = 1'b0;  // R14 R11
            sarNext[bitReg] = target[bitReg];
            serNext = target[bitReg];
          end
          if (cycReg == 8'(BIT_CYC - 1)) begin
            cycNext = '0;
            if (bitReg == 4'h0) begin
              stateNext = AC_DONE;
            end else begin
              bitNext = bitReg - 4'h1;
              clkNext = 1'b1;
            end
          end
        end
        AC_DONE: begin
          stateNext = AC_DONE;
        end
        default: begin
          stateNext = AC_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg <= AC_IDLE;
      sarReg   <= RESULT_RESET;
      bitReg   <= 4'hb;
      cycReg   <= 8'h00;
      clkReg   <= 1'b0;
      serReg   <= 1'b0;
    end else if (clkEn) begin
      stateReg <= stateNext;
      sarReg   <= sarNext;
      bitReg   <= bitNext;
      cycReg   <= cycNext;
      clkReg   <= clkNext;
      serReg   <= serNext;
    end
  end

  assign link.clockOut   = clkReg;
  assign link.status     = (stateReg == AC_CONV);  // R13 R4
  assign link.resultData = sarReg;
  assign link.serialOut  = serReg;
endmodule
`default_nettype wire

// *** core/asc_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
// short-cycle controller: counts bit clocks and drops convert at the stop bit
module asc_controller
  import asc_pkg::*;
(
  input  wire logic        core_clk,   // system clock
  input  wire logic        sys_rst,    // synchronous reset, active high
  input  wire logic        clkEn,      // clock enable, freezes state when low
  input  wire logic        startReq,   // pulse: request a conversion
  input  wire logic [10:0] stopSel,    // one-hot stop select, [6]=bit7..[0]=bit1, [10:7]=bits 11..8
  output logic             stopPulseN, // active-low stop pulse
  output logic             busy,       // conversion in progress
  output logic             resultValid,// pulse: result latched
  output logic [11:0]      result,     // captured result
  asc_link_if.controller   link        // controller side of the link
);
  //////////////////////////////////////////////////////////////////////////
  // state and decoded events
  logic [10:0] shiftReg, shiftNext;    // loaded selection, shifted per bit clock
  logic        latchReg, latchNext;    // set-reset latch driving convert
  logic        pendReg, pendNext;      // start requested, waiting for low time
  logic [3:0]  lowReg, lowNext;        // convert low time counter
  logic        clkDlyReg, clkDlyNext;  // bit clock level one cycle ago
  logic        stsDlyReg, stsDlyNext;  // status level one cycle ago
  logic        stopNReg, stopNNext;    // stop pulse register, active low
  logic        validReg, validNext;    // result pulse
  logic [11:0] resReg, resNext;        // captured result
  logic        clkFall;                // bit clock fell: one more bit valid
  logic        stsFall;                // status fell: conversion over
  logic        stopHit;                // selected stop bit reached this cycle
  logic        lowDone;                // convert low for the least low time

  // falling edge of a pin, from its level one cycle ago
  function automatic logic fellEdge(input logic prevLevel, input logic nowLevel);
    return prevLevel & ~nowLevel;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // edge detect: history follows the pins, edges decode against it
  always_comb begin
    clkDlyNext = link.clockOut;
    stsDlyNext = link.status;
    clkFall    = fellEdge(clkDlyReg, link.clockOut);  // R1
    stsFall    = fellEdge(stsDlyReg, link.status);    // R4
  end

  // history resets to the idle level of both pins: no false edge after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkDlyReg <= 1'b0;
      stsDlyReg <= 1'b0;
    end else if (clkEn) begin
      clkDlyReg <= clkDlyNext;
      stsDlyReg <= stsDlyNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stop counter: the selection moves one place per bit clock fall
  always_comb begin
    shiftNext = shiftReg;
    stopNNext = 1'b1;
    stopHit   = 1'b0;
    if (latchReg && clkFall) begin
      // bit k of the selection stops after bit k+1
      shiftNext = {1'b0, shiftReg[10:1]};  // R1 R8
      if (shiftReg[0]) begin
        // selected stop bit reached: one low cycle on the stop pulse
        stopHit   = 1'b1;
        stopNNext = 1'b0;  // R2
      end
    end
    if (stsFall || (!latchReg && !link.status)) begin
      // reload while idle and when status falls, ready for the next start
      shiftNext = stopSel;  // R4 R5 R6 R7
    end
  end

  // stop counter registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shiftReg <= 11'h000;
      stopNReg <= 1'b1;
    end else if (clkEn) begin
      shiftReg <= shiftNext;
      stopNReg <= stopNNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // convert latch, pending request and low-time counter
  always_comb begin
    latchNext = latchReg;
    pendNext  = pendReg | startReq;
    lowNext   = lowReg;
    lowDone   = (lowReg == 4'(LOW_CYC));
    if (!latchReg && !lowDone) begin
      // count the cycles convert has been low
      lowNext = lowReg + 4'h1;  // R15
    end
    if (stopHit) begin
      // stop pulse clears the latch: convert drops
      latchNext = 1'b0;  // R3
      lowNext   = '0;
    end
    if (stsFall) begin
      // a full conversion ends with status: convert drops as well
      latchNext = 1'b0;  // R12
      lowNext   = '0;
    end
    if (!latchReg && pendReg && lowDone) begin
      // set the latch again once the low time is met
      latchNext = 1'b1;  // R16 R15 R12
      pendNext  = startReq;
    end
  end

  // latch registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latchReg <= 1'b0;
      pendReg  <= 1'b0;
      lowReg   <= 4'h0;
    end else if (clkEn) begin
      latchReg <= latchNext;
      pendReg  <= pendNext;
      lowReg   <= lowNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result capture on the status fall
  always_comb begin
    validNext = 1'b0;
    resNext   = resReg;
    if (stsFall) begin
      // parallel data is valid once status is low
      validNext = 1'b1;  // R4
      resNext   = link.resultData;
    end
  end

  // result registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      validReg <= 1'b0;
      resReg   <= 12'h000;
    end else if (clkEn) begin
      validReg <= validNext;
      resReg   <= resNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.convertCmd = latchReg;  // R3
  assign stopPulseN      = stopNReg;
  assign busy            = latchReg;
  assign resultValid     = validReg;
  assign result          = resReg;
endmodule
`default_nettype wire

// *** testbench/asc_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// checker on the converter to controller link
module asc_properties
  import asc_pkg::*;
(
  input wire logic        core_clk,   // system clock
  input wire logic        sys_rst,    // sync reset
  input wire logic        convertCmd, // convert command
  input wire logic        clockOut,   // bit clock
  input wire logic        status,     // converting flag
  input wire logic [11:0] resultData, // parallel result
  input wire logic        serialOut   // serial result bit
);
  int lowCnt;  // cycles convert was low
  int highCnt; // cycles status was high
  int bitCnt;  // bit clock falls this conversion
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // counters run through reset so low time before a start is seen
  always_ff @(posedge core_clk) begin
    lowCnt <= convertCmd ? 0 : lowCnt + 1;
    highCnt <= status ? highCnt + 1 : 0;
    bitCnt <= !convertCmd ? 0 : bitCnt + int'($fell(clockOut));
  end
  ////////////////////////////////////////////////////////////////
  a_low_before_start: assert property ($rose(convertCmd) |-> lowCnt >= LOW_CYC)
    else $error("convert raised too soon");
  a_status_follows: assert property ($rose(convertCmd) |-> ##[1:3] status)
    else $error("status did not rise");
  a_clock_idle_low: assert property (!convertCmd && !$past(convertCmd) |-> !clockOut)
    else $error("bit clock runs while convert low");
  a_status_ends: assert property ($fell(convertCmd) |-> ##[0:3] !status)
    else $error("status stayed high after stop");
  a_conv_time: assert property ($fell(status) |-> highCnt * CLK_PERIOD_NS <= CONV_MAX_NS)
    else $error("conversion too long");
  a_conv_floor: assert property ($fell(status) && convertCmd |-> highCnt * CLK_PERIOD_NS >= CONV_MIN_NS)
    else $error("full conversion too short");
  a_serial_matches: assert property ($fell(clockOut) |-> serialOut == resultData[11 - bitCnt])
    else $error("serial bit differs from parallel bit");
  a_bit_limit: assert property ($fell(status) |-> bitCnt <= RES_BITS)
    else $error("too many bit clocks");
  a_convert_holds: assert property (status |-> convertCmd || $past(convertCmd, 2))
    else $error("status high without convert");
  a_sar_start: assert property ($rose(status) |-> ##[0:2] resultData == RESULT_RESET)
    else $error("sar not preset at start");
  a_clock_bounded: assert property ($rose(clockOut) |-> ##[1:9] !clockOut)
    else $error("bit clock stuck high");
  c_full_conv: cover property ($fell(status) && convertCmd);
  c_short_conv: cover property ($fell(convertCmd) && status);
  c_restart: cover property ($rose(convertCmd) && lowCnt == LOW_CYC + 1);
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
// drives both ends of the link and checks the captured results
module testbench;
  logic        core_clk = 1'b0;     // system clock
  logic        sys_rst = 1'b1;      // sync reset
  logic        clkEn = 1'b1;        // enable
  logic        bipolarMode = 1'b1;  // range select
  logic [11:0] sampleCode = 12'h000;// input code
  logic        startReq = 1'b0;     // request
  logic [10:0] stopSel = 11'h000;   // stop select
  logic        stopPulseN;          // stop pulse
  logic        busy;                // convert high
  logic        resultValid;         // result strobe
  logic [11:0] result;              // result
  int          fails = 0;           // mismatches
  int          checked = 0;         // comparisons
  asc_link_if link ();
  asc_converter asc_converter_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .bipolarMode(bipolarMode), .sampleCode(sampleCode), .link(link.converter));
  asc_controller asc_controller_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .startReq(startReq), .stopSel(stopSel), .stopPulseN(stopPulseN), .busy(busy),
    .resultValid(resultValid), .result(result), .link(link.controller));
  asc_properties asc_properties_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .convertCmd(link.convertCmd), .clockOut(link.clockOut), .status(link.status),
    .resultData(link.resultData), .serialOut(link.serialOut));
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task automatic checkCode(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: result %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // kept bits follow the range format, unresolved bits read as ones
  function automatic logic [11:0] expCode(input logic bip, input logic [11:0] code, input int n);
    logic [11:0] mask;
    mask = 12'hfff << (12 - n);
    return ((bip ? code : ~code) & mask) | ~mask;
  endfunction
  // one conversion stopping after n bits, checked against the model
  task automatic runConv(input logic bip, input logic [11:0] code, input int n);
    logic stopped;
    @(posedge core_clk);
    bipolarMode <= bip;
    sampleCode <= code;
    stopSel <= (n == 12) ? 11'h000 : 11'h001 << (n - 1);
    startReq <= 1'b1;
    @(posedge core_clk);
    startReq <= 1'b0;
    stopped = 1'b0;
    for (int i = 0; i < 300 && resultValid !== 1'b1; i++) begin
      @(negedge core_clk);
      if (stopPulseN === 1'b0) stopped = 1'b1;
    end
    if (resultValid !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: no result within limit", $time);
    end
    checkCode(result, expCode(bip, code, n));
    checkBit(stopped, n != 12);
    checkBit(busy, 1'b0);
  endtask
  // freeze both ends in mid conversion: result and bit clock must hold while enable is low
  task automatic testFreeze();
    logic [11:0] heldData;
    logic        heldClk;
    fork
      runConv(1'b1, 12'h6b3, 12);
      begin
        repeat (40) @(posedge core_clk);
        clkEn <= 1'b0;
        @(negedge core_clk);
        heldData = link.resultData;
        heldClk = link.clockOut;
        repeat (2) @(negedge core_clk);
        checkCode(link.resultData, heldData);
        checkBit(link.clockOut, heldClk);
        @(posedge core_clk);
        clkEn <= 1'b1;
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic testFormats();
    logic [11:0] codes [4] = '{12'h7ff, 12'h800, 12'h000, 12'hfff};
    for (int b = 0; b < 2; b++) begin
      foreach (codes[k]) runConv(b[0], codes[k], 12);
    end
  endtask
  task automatic testShortCycle();
    for (int n = 1; n < 12; n++) begin
      runConv(1'b1, 12'ha5c, n);
    end
  endtask
  task automatic testReload();
    runConv(1'b1, 12'h3c9, 4);
    runConv(1'b1, 12'h3c9, 12);
    runConv(1'b0, 12'h5a1, 12);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    testFormats();
    testShortCycle();
    testReload();
    testFreeze();
    results();
  end
  // cut a hang short
  initial begin
    #80000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
